//--- logic/wdt_pkg.sv
// Constants, field layouts and types for the sleep-aware watchdog
package wdt_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int BASE_PERIOD_US = 18000;
    localparam int RC_FREQ_HZ = 37000;
    localparam int US_PER_S = 1000000;
    localparam int BASE_TICKS = (BASE_PERIOD_US * RC_FREQ_HZ) / US_PER_S;
    localparam int CNT_W = 16;
    localparam int POST_W = 7;

    // ************************************************************
    // Instruction encodings
    // ************************************************************
    localparam logic [13:0] OP_SLEEP = 14'h0063;
    localparam logic [13:0] OP_OPTION_LOAD = 14'h0062;

    // ************************************************************
    // Register map, byte addresses
    // ************************************************************
    localparam logic [7:0] ADDR_OPTION = 8'h00;
    localparam logic [7:0] ADDR_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_COUNT = 8'h10;

    // ************************************************************
    // Field layouts and reset values
    // ************************************************************
    localparam logic [7:0] OPTION_RESET = 8'hFF;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
    localparam int FLAG_TO_BIT = 1;
    localparam int FLAG_PD_BIT = 0;
    localparam int FLAG_SLEEP_BIT = 2;
    localparam int IRQ_RESET_BIT = 0;
    localparam int IRQ_WAKE_BIT = 1;

    typedef struct packed {
        logic [3:0] spare;
        logic assign_wdt;
        logic [2:0] ratio;
    } option_t;

    typedef struct packed {
        logic reset_ev;
        logic wake_ev;
    } events_t;

    typedef enum logic {
        RUN,
        ASLEEP
    } core_state_t;

endpackage : wdt_pkg

//--- logic/wdt_sleep_wake.sv
// Watchdog timer with sleep wake-up, RC tick input and Wishbone slave
`timescale 1ns/1ps
`default_nettype none

module wdt_sleep_wake #(
    parameter int BASE_TICKS = wdt_pkg::BASE_TICKS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // RC oscillator and fuse pins
    input wire logic rc_clk_i,
    input wire logic watchdog_enable_fuse_i,
    // Core instruction side
    input wire logic instr_valid_i,
    input wire logic [13:0] instr_i,
    input wire logic [7:0] w_data_i,
    input wire logic clear_watchdog_instr_i,
    // Core control outputs
    output logic device_reset_o,
    output logic wake_o,
    output logic sleeping_o,
    output logic main_osc_stop_o,
    output logic timeout_flag_n_o,
    output logic powerdown_flag_n_o,
    output logic irq_o,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic rc_s1_q, rc_s2_q, rc_s3_q;
    logic fuse_s1_q, fuse_s2_q;
    logic rc_tick;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rc_s1_q <= 1'b0;
            rc_s2_q <= 1'b0;
            rc_s3_q <= 1'b0;
            fuse_s1_q <= 1'b0;
            fuse_s2_q <= 1'b0;
        end else begin
            rc_s1_q <= rc_clk_i;
            rc_s2_q <= rc_s1_q;
            rc_s3_q <= rc_s2_q;
            fuse_s1_q <= watchdog_enable_fuse_i;
            fuse_s2_q <= fuse_s1_q;
        end
    end

    // ************************************************************
    // Tick qualifier
    // ************************************************************
    // Flop reset level may differ from the pin: no tick until filled
    logic [2:0] rc_fill_q, rc_fill_d;

    always_comb begin
        rc_fill_d = {rc_fill_q[1:0], 1'b1};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rc_fill_q <= '0;
        end else begin
            rc_fill_q <= rc_fill_d;
        end
    end

    // Rising edge of the RC clock, seen only after two flops
    assign rc_tick = rc_fill_q[2] & rc_s2_q & ~rc_s3_q;

    // ************************************************************
    // Instruction decode and bus strobes
    // ************************************************************
    logic sleep_cmd, option_cmd, clear_cmd;
    logic bus_req, bus_wr, bus_rd;
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;

    assign sleep_cmd = instr_valid_i && (instr_i == wdt_pkg::OP_SLEEP);
    assign option_cmd = instr_valid_i && (instr_i == wdt_pkg::OP_OPTION_LOAD);
    assign clear_cmd = clear_watchdog_instr_i | sleep_cmd;
    assign bus_req = cyc_i & stb_i;
    // Write and read side effects fire at the edge where ack is high
    assign bus_wr = bus_req & we_i & ack_q;
    assign bus_rd = bus_req & ~we_i & ack_q;

    // ************************************************************
    // Option register
    // ************************************************************
    wdt_pkg::option_t option_q, option_d;

    always_comb begin
        option_d = option_q;
        if (option_cmd) begin
            option_d = wdt_pkg::option_t'(w_data_i);
        end else if (bus_wr && adr_i == wdt_pkg::ADDR_OPTION && sel_i[0]) begin
            option_d = wdt_pkg::option_t'(dat_i[7:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            option_q <= wdt_pkg::option_t'(wdt_pkg::OPTION_RESET);
        end else begin
            option_q <= option_d;
        end
    end

    // ************************************************************
    // Base counter and postscaler
    // ************************************************************
    localparam logic [wdt_pkg::CNT_W-1:0] BASE_LAST =
        wdt_pkg::CNT_W'(BASE_TICKS - 1);
    localparam logic [wdt_pkg::POST_W:0] POST_ONE = 8'h01;

    logic [wdt_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [wdt_pkg::POST_W-1:0] post_q, post_d;
    logic [wdt_pkg::POST_W-1:0] post_last;
    logic base_wrap, expire;

    // Ratio field picks 1:1 up to 1:128 in powers of two
    assign post_last = option_q.assign_wdt ?
        wdt_pkg::POST_W'((POST_ONE << option_q.ratio) - POST_ONE) :
        '0;
    assign base_wrap = rc_tick && (cnt_q == BASE_LAST);
    // Fuse cleared: no tick ever reaches expiry
    assign expire = fuse_s2_q && !clear_cmd && base_wrap &&
        (post_q == post_last);

    always_comb begin
        cnt_d = cnt_q;
        post_d = post_q;
        if (!fuse_s2_q) begin
            cnt_d = '0;
            post_d = '0;
        end else if (clear_cmd) begin
            // Clear beats a tick in the same cycle
            cnt_d = '0;
            if (option_q.assign_wdt || sleep_cmd) begin
                post_d = '0;
            end
        end else if (rc_tick) begin
            if (base_wrap) begin
                cnt_d = '0;
                post_d = (post_q == post_last) ? '0 :
                    post_q + wdt_pkg::POST_W'(1);
            end else begin
                cnt_d = cnt_q + wdt_pkg::CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            post_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            post_q <= post_d;
        end
    end

    // ************************************************************
    // Core state, status flags, reset and wake
    // ************************************************************
    wdt_pkg::core_state_t state_q, state_d;
    logic to_n_q, to_n_d, pd_n_q, pd_n_d;
    logic rst_pulse_q, rst_pulse_d, wake_q, wake_d;
    wdt_pkg::events_t ev;

    assign ev.reset_ev = expire && (state_q == wdt_pkg::RUN);
    assign ev.wake_ev = expire && (state_q == wdt_pkg::ASLEEP);

    always_comb begin
        state_d = state_q;
        to_n_d = to_n_q;
        pd_n_d = pd_n_q;
        rst_pulse_d = ev.reset_ev;
        wake_d = ev.wake_ev;
        unique case (state_q)
            wdt_pkg::RUN: begin
                if (sleep_cmd) begin
                    state_d = wdt_pkg::ASLEEP;
                    to_n_d = 1'b1;
                    pd_n_d = 1'b0;
                end
            end
            wdt_pkg::ASLEEP: begin
                if (ev.wake_ev) begin
                    state_d = wdt_pkg::RUN;
                end
            end
        endcase
        if (expire) begin
            to_n_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= wdt_pkg::RUN;
            to_n_q <= 1'b1;
            pd_n_q <= 1'b1;
            rst_pulse_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            state_q <= state_d;
            to_n_q <= to_n_d;
            pd_n_q <= pd_n_d;
            rst_pulse_q <= rst_pulse_d;
            wake_q <= wake_d;
        end
    end

    assign device_reset_o = rst_pulse_q;
    assign wake_o = wake_q;
    assign sleeping_o = (state_q == wdt_pkg::ASLEEP);
    // Main clock stops in sleep; this block must stay on clk_i
    assign main_osc_stop_o = (state_q == wdt_pkg::ASLEEP);
    assign timeout_flag_n_o = to_n_q;
    assign powerdown_flag_n_o = pd_n_q;

    // ************************************************************
    // Interrupt status and mask
    // ************************************************************
    logic [1:0] irq_st_q, irq_st_d, irq_mask_q, irq_mask_d, irq_set;

    assign irq_set[wdt_pkg::IRQ_RESET_BIT] = ev.reset_ev;
    assign irq_set[wdt_pkg::IRQ_WAKE_BIT] = ev.wake_ev;

    always_comb begin
        irq_st_d = irq_st_q;
        irq_mask_d = irq_mask_q;
        if (bus_rd && adr_i == wdt_pkg::ADDR_IRQ_STATUS) begin
            // Clear only what the read returned, later events stay
            irq_st_d = irq_st_q & ~dat_q[1:0];
        end
        // Set after clear so a same-cycle event survives the read
        irq_st_d = irq_st_d | irq_set;
        if (bus_wr && adr_i == wdt_pkg::ADDR_IRQ_MASK && sel_i[0]) begin
            irq_mask_d = dat_i[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_st_q <= '0;
            irq_mask_q <= wdt_pkg::IRQ_MASK_RESET;
        end else begin
            irq_st_q <= irq_st_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    assign irq_o = |(irq_st_q & irq_mask_q);

    // ************************************************************
    // Wishbone answer: ack one cycle after the request
    // ************************************************************
    always_comb begin
        ack_d = bus_req & ~ack_q;
        dat_d = '0;
        if (bus_req && !ack_q && !we_i) begin
            unique case (adr_i)
                wdt_pkg::ADDR_OPTION: dat_d[7:0] = option_q;
                wdt_pkg::ADDR_FLAGS: begin
                    dat_d[wdt_pkg::FLAG_TO_BIT] = to_n_q;
                    dat_d[wdt_pkg::FLAG_PD_BIT] = pd_n_q;
                    dat_d[wdt_pkg::FLAG_SLEEP_BIT] =
                        (state_q == wdt_pkg::ASLEEP);
                end
                wdt_pkg::ADDR_IRQ_STATUS: dat_d[1:0] = irq_st_q;
                wdt_pkg::ADDR_IRQ_MASK: dat_d[1:0] = irq_mask_q;
                wdt_pkg::ADDR_COUNT: dat_d[wdt_pkg::CNT_W-1:0] = cnt_q;
                default: dat_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

endmodule : wdt_sleep_wake

`default_nettype wire

//--- testbench/wdt_checker.sv
// Assertion checker for the sleep-aware watchdog
`timescale 1ns/1ps
`default_nettype none
module wdt_checker #(
    parameter int BASE_TICKS = wdt_pkg::BASE_TICKS
) (
    // Clock, reset, core and bus inputs
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic watchdog_enable_fuse_i,
    input wire logic instr_valid_i,
    input wire logic [13:0] instr_i,
    input wire logic clear_watchdog_instr_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    // Watched outputs
    input wire logic device_reset_o,
    input wire logic wake_o,
    input wire logic sleeping_o,
    input wire logic main_osc_stop_o,
    input wire logic timeout_flag_n_o,
    input wire logic powerdown_flag_n_o,
    input wire logic ack_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_reset_when_run: assert property (device_reset_o |-> !sleeping_o)
        else $error("reset pulse while asleep");
    a_wake_from_sleep: assert property (
        wake_o |-> !sleeping_o && $past(sleeping_o))
        else $error("wake pulse without prior sleep");
    a_expiry_clears_to: assert property (
        device_reset_o || wake_o |-> !timeout_flag_n_o)
        else $error("timeout flag not cleared on expiry");
    a_fuse_off_quiet: assert property (
        !watchdog_enable_fuse_i [*4] |-> !device_reset_o && !wake_o)
        else $error("expiry with fuse off");
    a_sleep_flags: assert property (
        instr_valid_i && instr_i == wdt_pkg::OP_SLEEP && !sleeping_o
        |=> sleeping_o && timeout_flag_n_o && !powerdown_flag_n_o)
        else $error("sleep did not set state and flags");
    a_osc_stop_sleep: assert property (main_osc_stop_o == sleeping_o)
        else $error("oscillator stop differs from sleep state");
    a_clear_no_expiry: assert property (
        clear_watchdog_instr_i |=> !device_reset_o && !wake_o)
        else $error("expiry right after clear");
    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_next_cycle: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack not given next cycle");

    c_reset: cover property (device_reset_o);
    c_wake: cover property (wake_o);
    c_clear: cover property (clear_watchdog_instr_i);
endmodule : wdt_checker
bind wdt_sleep_wake wdt_checker #(.BASE_TICKS(BASE_TICKS)) i_wdt_checker (
    .clk_i, .rst_i, .watchdog_enable_fuse_i, .instr_valid_i, .instr_i,
    .clear_watchdog_instr_i, .cyc_i, .stb_i, .device_reset_o, .wake_o,
    .sleeping_o, .main_osc_stop_o, .timeout_flag_n_o, .powerdown_flag_n_o,
    .ack_o);
`default_nettype wire

//--- testbench/wdt_core_model.sv
// Core-side partner: RC oscillator and reset/wake bookkeeping
`timescale 1ns/1ps
`default_nettype none
module wdt_core_model #(
    parameter int RC_HALF_NS = 200
) (
    // Oscillator
    output logic rc_clk_o,
    // Watchdog events
    input wire logic clk_i,
    input wire logic device_reset_i,
    input wire logic wake_i,
    output var int resets_o,
    output var int wakes_o
);
    int resets_q = 0;
    int wakes_q = 0;
    // Free running, never gated by sleep; odd offset avoids clk edges
    initial begin
        rc_clk_o = 1'b0;
        #7;
        forever #(RC_HALF_NS) rc_clk_o = ~rc_clk_o;
    end
    always @(posedge clk_i) begin
        resets_q <= resets_q + int'(device_reset_i);
        wakes_q <= wakes_q + int'(wake_i);
    end
    assign resets_o = resets_q;
    assign wakes_o = wakes_q;
endmodule : wdt_core_model
`default_nettype wire

//--- testbench/wdt_sleep_wake_tb.sv
// Self-checking bench for the sleep-aware watchdog
`timescale 1ns/1ps
`default_nettype none
module wdt_sleep_wake_tb;
    localparam int BT = 4;
    localparam int RCP = 8;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic fuse = 1'b1;
    logic iv = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic [7:0] wreg = 8'h00;
    logic clr = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] dat, rdat;
    logic rc, drst, wake, slp, ostop, timeout_n, pdown_n, irq, ack;
    int num_errors = 0;
    int num_checks = 0;
    int resets, wakes, r;
    always #25 clk_i = ~clk_i;
    wdt_sleep_wake #(.BASE_TICKS(BT)) i_wdt_sleep_wake (.clk_i, .rst_i,
        .rc_clk_i(rc), .watchdog_enable_fuse_i(fuse), .instr_valid_i(iv),
        .instr_i(instr), .w_data_i(wreg), .clear_watchdog_instr_i(clr),
        .device_reset_o(drst), .wake_o(wake), .sleeping_o(slp),
        .main_osc_stop_o(ostop), .timeout_flag_n_o(timeout_n),
        .powerdown_flag_n_o(pdown_n), .irq_o(irq), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat),
        .ack_o(ack));
    wdt_core_model #(.RC_HALF_NS(RCP * 25)) i_wdt_core_model (.clk_i,
        .rc_clk_o(rc), .device_reset_i(drst), .wake_i(wake),
        .resets_o(resets), .wakes_o(wakes));
    task automatic chk(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Classic cycle; data taken at the ack edge only
    task automatic wb(input logic w, input logic [7:0] a, input int d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = dat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 0);
        chk("read data", rdat, e);
    endtask : rd
    task automatic exec(input logic [13:0] op, input logic c);
        @(posedge clk_i);
        iv <= !c;
        clr <= c;
        instr <= op;
        @(posedge clk_i);
        iv <= 1'b0;
        clr <= 1'b0;
        @(posedge clk_i);
    endtask : exec
    // Second gap is clean even if the first follows a ratio change
    task automatic gap(input int ratio);
        int n;
        n = 0;
        @(posedge clk_i iff drst);
        do begin
            @(posedge clk_i);
            n++;
        end while (drst !== 1'b1);
        chk("expiry gap", n, BT * ratio * RCP);
    endtask : gap
    task automatic t_regs;
        rd(wdt_pkg::ADDR_OPTION, 32'hFF);
        rd(wdt_pkg::ADDR_IRQ_MASK, 32'h0);
        rd(wdt_pkg::ADDR_FLAGS, 32'h3);
        rd(8'h20, 32'h0);
    endtask : t_regs
    task automatic t_expiry;
        wb(1'b1, wdt_pkg::ADDR_OPTION, 0);
        gap(1);
        chk("timeout flag", timeout_n, 1'b0);
        chk("masked irq", irq, 1'b0);
        rd(wdt_pkg::ADDR_IRQ_STATUS, 32'h1);
        wb(1'b1, wdt_pkg::ADDR_IRQ_MASK, 1);
        @(posedge clk_i iff drst);
        @(posedge clk_i);
        chk("irq", irq, 1'b1);
        wb(1'b1, wdt_pkg::ADDR_IRQ_MASK, 0);
        for (int n = 1; n < 8; n += 6) begin
            wb(1'b1, wdt_pkg::ADDR_OPTION, 8 + n);
            gap(1 << n);
        end
    endtask : t_expiry
    task automatic t_clear_sleep;
        wb(1'b1, wdt_pkg::ADDR_OPTION, 0);
        r = resets;
        repeat (20) exec(14'h0000, 1'b1);
        chk("resets", resets, r);
        rd(wdt_pkg::ADDR_IRQ_STATUS, 32'h1);
        exec(14'h0000, 1'b1);
        exec(wdt_pkg::OP_SLEEP, 1'b0);
        chk("sleep", {slp, ostop, timeout_n, pdown_n}, 4'hE);
        wb(1'b1, wdt_pkg::ADDR_IRQ_MASK, 2);
        @(posedge clk_i iff wake);
        chk("asleep after wake", slp, 1'b0);
        chk("timeout flag after wake", timeout_n, 1'b0);
        chk("resets in sleep", resets - r, 0);
        chk("wake irq", irq, 1'b1);
        rd(wdt_pkg::ADDR_IRQ_STATUS, 32'h2);
        wreg <= 8'h5A;
        exec(wdt_pkg::OP_OPTION_LOAD, 1'b0);
        rd(wdt_pkg::ADDR_OPTION, 32'h5A);
    endtask : t_clear_sleep
    task automatic t_fuse;
        wb(1'b1, wdt_pkg::ADDR_OPTION, 0);
        fuse <= 1'b0;
        // Pulses already on their way through the synchroniser
        repeat (4) @(posedge clk_i);
        r = resets + wakes;
        repeat (400) @(posedge clk_i);
        chk("events", resets + wakes, r);
        rd(wdt_pkg::ADDR_COUNT, 32'h0);
    endtask : t_fuse
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #1000000;
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_expiry();
        t_clear_sleep();
        t_fuse();
        print_verdict();
    end
endmodule : wdt_sleep_wake_tb
`default_nettype wire
